// ==== rtl/pcs_cmd_status.sv ====
// Command and status register pair with bus gating outputs
`timescale 1ns/10ps
module pcs_cmd_status (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Configuration access
   input  pcs_pkg::pcs_cfg_req_t cfgReq,
   output logic                  cfgAck,
   output logic                  cfgHit,
   output logic [31:0]           cfgRdata,
   // Bus and function events
   input  pcs_pkg::pcs_evt_t     evt,
   // Enables and gated requests
   output pcs_pkg::pcs_ctl_t     ctl,
   output logic                  busReq,
   output logic                  mwiCmd,
   output logic                  memClaim,
   // Open-drain pins: system error, parity error, interrupt
   output logic                  serrO,
   output logic                  serrOe,
   output logic                  perrO,
   output logic                  perrOe,
   output logic                  intaO,
   output logic                  intaOe
);
   import pcs_pkg::*;

   typedef struct packed {
      logic [15:0] cmd;
      logic        intStat;
      logic        serrOe;
      logic        perrOe;
      logic        intOe;
      logic        ack;
      logic        hit;
      logic        rdSeen;
      logic [31:0] rdata;
   } pcs_state_t;

   pcs_state_t             s_r;
   pcs_state_t             s_nxt;
   logic [NUM_STICKY-1:0] flags;
   logic [NUM_STICKY-1:0] setEv;
   logic [NUM_STICKY-1:0] clrEv;
   logic                  wrHit;
   logic [15:0]           statView;

   ////////////////////////////////////////////////////////////////////
   // Decode of the one dword this block owns
   function automatic logic isCmdStat(input logic [7:0] a);
      return a[7:2] == CMD_OFS[7:2];
   endfunction

   // Status as read; constant fields are wired, not stored
   function automatic logic [15:0] buildStat(input logic [NUM_STICKY-1:0] f,
                                             input logic intS);
      logic [15:0] v;
      v = STAT_RESET & 16'h0010;
      v[ST_DEVSEL_LO +: 2] = DEVSEL_MEDIUM;
      v[ST_PAR]    = f[FL_PAR];
      v[ST_SYS]    = f[FL_SYS];
      v[ST_MABT]   = f[FL_MABT];
      v[ST_TABT_R] = f[FL_TABT_R];
      v[ST_TABT_S] = f[FL_TABT_S];
      v[ST_DPAR]   = f[FL_DPAR];
      v[ST_INT]    = intS;
      return v;
   endfunction

   assign wrHit    = cfgReq.wr & isCmdStat(cfgReq.addr);
   assign statView = buildStat(flags, s_r.intStat);

   ////////////////////////////////////////////////////////////////////
   // Sticky flag events; status byte 1 holds every clearable bit
   always_comb begin
      setEv = '0;
      setEv[FL_PAR]    = evt.addrParityErr | evt.dataParityErr;
      setEv[FL_SYS]    = evt.serrReq & s_r.cmd[CMD_SERR];
      setEv[FL_MABT]   = evt.masterAbort;
      setEv[FL_TABT_R] = evt.tgtAbortRecv;
      setEv[FL_TABT_S] = evt.tgtAbortSig;
      setEv[FL_DPAR]   = evt.perrSeen & evt.masterPhase
                         & s_r.cmd[CMD_PERR];
      clrEv = '0;
      if (wrHit && cfgReq.be[3]) begin
         clrEv[FL_PAR]    = cfgReq.wdata[16 + ST_PAR];
         clrEv[FL_SYS]    = cfgReq.wdata[16 + ST_SYS];
         clrEv[FL_MABT]   = cfgReq.wdata[16 + ST_MABT];
         clrEv[FL_TABT_R] = cfgReq.wdata[16 + ST_TABT_R];
         clrEv[FL_TABT_S] = cfgReq.wdata[16 + ST_TABT_S];
         clrEv[FL_DPAR]   = cfgReq.wdata[16 + ST_DPAR];
      end
   end

   pcs_sticky_flags #(
      .W (NUM_STICKY)
   ) u_flags (
      .clk   (clk),
      .nrst  (nrst),
      .setEv (setEv),
      .clrEv (clrEv),
      .flags (flags)
   );

   ////////////////////////////////////////////////////////////////////
   // Next state: command writes, pin drivers, read data
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = cfgReq.rd | cfgReq.wr;
      s_nxt.hit = (cfgReq.rd | cfgReq.wr) & isCmdStat(cfgReq.addr);
      s_nxt.rdSeen = cfgReq.rd;
      // Only writable bits move; reserved and hardwired stay zero
      for (int b = 0; b < 2; b++) begin
         if (wrHit && cfgReq.be[b]) begin
            s_nxt.cmd[b*8 +: 8] = (cfgReq.wdata[b*8 +: 8] & CMD_RW_MASK[b*8 +: 8])
                                 | (s_r.cmd[b*8 +: 8] & ~CMD_RW_MASK[b*8 +: 8]);
         end
      end
      s_nxt.intStat = evt.intPending;
      s_nxt.intOe   = evt.intPending & ~s_r.cmd[CMD_INT_GATE];
      s_nxt.serrOe  = evt.serrReq & s_r.cmd[CMD_SERR];
      s_nxt.perrOe  = evt.perrReq & s_r.cmd[CMD_PERR];
      // Unclaimed offsets read zero so the header mux can OR us in
      if (cfgReq.rd && isCmdStat(cfgReq.addr)) begin
         s_nxt.rdata = {statView, s_r.cmd & CMD_RW_MASK};
      end else begin
         s_nxt.rdata = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_r <= '{cmd: CMD_RESET, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs; requests are gated combinationally so no cycle is lost
   assign cfgAck   = s_r.ack;
   assign cfgHit   = s_r.hit;
   assign cfgRdata = s_r.rdata;
   assign ctl.initiator_en          = s_r.cmd[CMD_MASTER];
   assign ctl.mem_space_en          = s_r.cmd[CMD_MEM];
   assign ctl.write_invalidate_en   = s_r.cmd[CMD_MWI];
   assign ctl.parity_report_en      = s_r.cmd[CMD_PERR];
   assign ctl.system_error_drive_en = s_r.cmd[CMD_SERR];
   assign ctl.int_gate              = s_r.cmd[CMD_INT_GATE];
   assign busReq   = evt.busWanted & s_r.cmd[CMD_MASTER];
   // Write-invalidate only when also allowed to master
   assign mwiCmd   = evt.mwiWanted & s_r.cmd[CMD_MWI]
                     & s_r.cmd[CMD_MASTER];
   assign memClaim = evt.memHit & s_r.cmd[CMD_MEM];
   // Open-drain pins only ever pull low
   assign serrO  = 1'b0;
   assign serrOe = s_r.serrOe;
   assign perrO  = 1'b0;
   assign perrOe = s_r.perrOe;
   assign intaO  = 1'b0;
   assign intaOe = s_r.intOe;

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   logic rdHitPast;
   // Read answer on show; strobe kept in state so no sampled function is needed here
   assign rdHitPast = cfgAck & cfgHit & s_r.rdSeen;

   cmdZeros_a: assert property (
      rdHitPast |-> (cfgRdata[15:0] & ~CMD_RW_MASK) == '0)
      else $error("hardwired command bit read nonzero");
   cmdWrite_a: assert property (
      wrHit && (&cfgReq.be[1:0]) |=> ctl.int_gate == $past(cfgReq.wdata[CMD_INT_GATE])
      && ctl.initiator_en == $past(cfgReq.wdata[CMD_MASTER]))
      else $error("command write not stored");
   intGate_a: assert property (
      intaOe |-> !$past(ctl.int_gate) && $past(evt.intPending))
      else $error("interrupt driven while gated");
   // Read data leaves two edges after the pending level that it shows
   intFlag_a: assert property (
      rdHitPast |-> cfgRdata[16 + ST_INT] == $past(evt.intPending, 2))
      else $error("interrupt status wrong");
   serrGate_a: assert property (
      evt.serrReq && ctl.system_error_drive_en |=> serrOe && flags[FL_SYS])
      else $error("system error not driven or flagged");
   serrOff_a: assert property (serrOe |-> $past(ctl.system_error_drive_en))
      else $error("system error driven while disabled");
   perrGate_a: assert property (
      perrOe |-> $past(ctl.parity_report_en && evt.perrReq))
      else $error("parity error driven while disabled");
   mwiGate_a: assert property (
      mwiCmd |-> ctl.write_invalidate_en && ctl.initiator_en)
      else $error("write-invalidate used while disabled");
   busGate_a: assert property (busReq |-> ctl.initiator_en)
      else $error("bus request while mastering off");
   memGate_a: assert property (memClaim |-> ctl.mem_space_en && evt.memHit)
      else $error("memory claim while disabled");
   parFlag_a: assert property (
      evt.addrParityErr || evt.dataParityErr |=> flags[FL_PAR])
      else $error("parity flag not set");
   abortFlags_a: assert property (
      evt.masterAbort || evt.tgtAbortRecv || evt.tgtAbortSig
      |=> (flags[FL_MABT] || !$past(evt.masterAbort))
      && (flags[FL_TABT_R] || !$past(evt.tgtAbortRecv))
      && (flags[FL_TABT_S] || !$past(evt.tgtAbortSig)))
      else $error("abort flag not set");
   flagHold_a: assert property (
      !(|setEv) && !(wrHit && cfgReq.be[3]) |=> $stable(flags))
      else $error("sticky flag moved without cause");
   constStat_a: assert property (
      rdHitPast |-> cfgRdata[16 + ST_DEVSEL_LO +: 2] == DEVSEL_MEDIUM
      && cfgRdata[16 + ST_CAP])
      else $error("hardwired status field wrong");
   dparFlag_a: assert property (
      $rose(flags[FL_DPAR]) |-> $past(evt.perrSeen && evt.masterPhase
      && ctl.parity_report_en))
      else $error("data parity flag without cause");

   rdCmd_c:  cover property (rdHitPast);
   w1c_c:    cover property (wrHit && cfgReq.be[3] && cfgReq.wdata[31] && flags[FL_PAR]);
   intOut_c: cover property (evt.intPending && !ctl.int_gate ##1 intaOe);
   serr_c:   cover property (serrOe && flags[FL_SYS]);
endmodule

// ==== rtl/pcs_pkg.sv ====
// Constants and carrier types for the command/status register pair
// How it works
// - Command bits 15..11 read zero, writes ignored
// - Command bit 10 set blocks interrupt output
// - Command bit 9 always reads zero
// - Command bit 8 gates the system error driver
// - Command bit 7 reads zero, writes ignored
// - Command bit 6 gates parity error driving
// - Command bit 5 reads zero, no snooping
// - Command bit 4 allows write-invalidate commands
// - Command bit 3 zero, special cycles ignored
// - Command bit 2 gates bus requests
// - Command bit 1 gates memory cycle claims
// - Command bit 0 zero, no port claims
// - Status 15 sets on any parity error
// - Status 14 sets when system error driven
// - Status 13 sets on received master abort
// - Status 12 sets on received target abort
// - Status 11 sets on signaled target abort
// - Status 3 shows pending interrupt, ignores gate
// - Status 10..9 read medium select code
// - Status 4 always reads one
// - Status 8 sets on master data parity
package pcs_pkg;
   // Configuration dword holding command (low) and status (high)
   localparam logic [7:0]  CMD_OFS       = 8'h04;
   localparam logic [7:0]  STAT_OFS      = 8'h06;
   localparam logic [15:0] CMD_RESET     = 16'h0000;
   localparam logic [15:0] STAT_RESET    = 16'h0210;
   localparam logic [15:0] CMD_RW_MASK   = 16'h0556;
   // Command field positions
   localparam int CMD_INT_GATE = 10;
   localparam int CMD_SERR     = 8;
   localparam int CMD_PERR     = 6;
   localparam int CMD_MWI      = 4;
   localparam int CMD_MASTER   = 2;
   localparam int CMD_MEM      = 1;
   // Status field positions
   localparam int ST_PAR       = 15;
   localparam int ST_SYS       = 14;
   localparam int ST_MABT      = 13;
   localparam int ST_TABT_R    = 12;
   localparam int ST_TABT_S    = 11;
   localparam int ST_DEVSEL_LO = 9;
   localparam int ST_DPAR      = 8;
   localparam int ST_CAP       = 4;
   localparam int ST_INT       = 3;
   localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
   // Sticky flag vector: index order within the flag block
   localparam int NUM_STICKY = 6;
   localparam int FL_DPAR    = 0;
   localparam int FL_TABT_S  = 1;
   localparam int FL_TABT_R  = 2;
   localparam int FL_MABT    = 3;
   localparam int FL_SYS     = 4;
   localparam int FL_PAR     = 5;

   // Configuration access request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } pcs_cfg_req_t;

   // Bus and function events
   typedef struct packed {
      logic addrParityErr;
      logic dataParityErr;
      logic serrReq;
      logic perrReq;
      logic perrSeen;
      logic masterPhase;
      logic masterAbort;
      logic tgtAbortRecv;
      logic tgtAbortSig;
      logic intPending;
      logic memHit;
      logic mwiWanted;
      logic busWanted;
   } pcs_evt_t;

   // Enables seen by the master, target and parity logic
   typedef struct packed {
      logic initiator_en;
      logic mem_space_en;
      logic write_invalidate_en;
      logic parity_report_en;
      logic system_error_drive_en;
      logic int_gate;
   } pcs_ctl_t;
endpackage

// ==== rtl/pcs_sticky_flags.sv ====
// Sticky error flags with write-one-to-clear, set dominant
`timescale 1ns/10ps
module pcs_sticky_flags #(
   parameter int W = 6
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // Hardware set and software clear
   input  wire logic [W-1:0] setEv,
   input  wire logic [W-1:0] clrEv,
   // Flag state
   output logic      [W-1:0] flags
);
   typedef struct packed {
      logic [W-1:0] fl;
   } pcs_flag_st_t;

   pcs_flag_st_t s_r;
   pcs_flag_st_t s_nxt;
   wire logic [W-1:0] bitNxt;

   ////////////////////////////////////////////////////////////////////
   // Per-bit update; an event in the clearing cycle still lands
   genvar i;
   for (i = 0; i < W; i++) begin : g_bit
      assign bitNxt[i] = setEv[i] | (s_r.fl[i] & ~clrEv[i]);
   end

   // One process owns the whole next state
   always_comb begin
      s_nxt    = s_r;
      s_nxt.fl = bitNxt;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign flags = s_r.fl;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   setWins_a: assert property (|setEv |=> (flags & $past(setEv)) == $past(setEv))
      else $error("set event lost");
   clrOnly_a: assert property (
      ((clrEv & ~setEv & flags) != '0) |=> (flags & $past(clrEv & ~setEv)) == '0)
      else $error("flag not cleared");
endmodule

// ==== sim/pcs_cfg_host.sv ====
// Configuration host model issuing single-dword accesses to the register pair
`timescale 1ns/10ps
module pcs_cfg_host (
   // Clock
   input  wire logic             clk,
   // Request side
   output pcs_pkg::pcs_cfg_req_t cfgReq,
   // Answer side
   input  wire logic             cfgAck,
   input  wire logic             cfgHit,
   input  wire logic [31:0]      cfgRdata
);
   import pcs_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // Idle until the first access
   initial cfgReq = '0;
   // Strobe for one edge, then the released fields show inverted junk
   task automatic access(input logic rd, input logic wr, input logic [7:0] a,
                         input logic [3:0] be, input logic [31:0] d,
                         output logic ack, output logic hit, output logic [31:0] q);
      @(posedge clk);
      cfgReq <= '{rd: rd, wr: wr, addr: a, be: be, wdata: d};
      @(posedge clk);
      cfgReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~be, wdata: ~d};
      #1;
      ack = cfgAck;
      hit = cfgHit;
      q = cfgRdata;
   endtask
endmodule

// ==== sim/test_pcs_cmd_status.sv ====
// Self-checking bench for the command and status register pair
`timescale 1ns/10ps
module test_pcs_cmd_status;
   import pcs_pkg::*;
   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   pcs_cfg_req_t      cfgReq;
   logic              cfgAck, cfgHit, busReq, mwiCmd, memClaim;
   logic [31:0]       cfgRdata;
   pcs_evt_t          evt = '0;
   pcs_ctl_t          ctl, ctlExp;
   logic              serrO, serrOe, perrO, perrOe, intaO, intaOe;
   logic [15:0]       c, st;
   int                n_mismatch = 0;
   int                cmp_count = 0;
   ////////////////////////////////////////////////////////////////////////////
   pcs_cmd_status pcs_cmd_status_i (.clk(clk), .nrst(nrst), .cfgReq(cfgReq),
      .cfgAck(cfgAck), .cfgHit(cfgHit), .cfgRdata(cfgRdata), .evt(evt), .ctl(ctl),
      .busReq(busReq), .mwiCmd(mwiCmd), .memClaim(memClaim), .serrO(serrO),
      .serrOe(serrOe), .perrO(perrO), .perrOe(perrOe), .intaO(intaO), .intaOe(intaOe));
   pcs_cfg_host pcs_cfg_host_i (.clk(clk), .cfgReq(cfgReq), .cfgAck(cfgAck),
      .cfgHit(cfgHit), .cfgRdata(cfgRdata));
   // 25 MHz clock
   initial begin
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Compare tasks, one per kind of result
   task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask
   task automatic check_bit(input string what, input logic e, input logic g);
      check_word(what, {31'h0, e}, {31'h0, g});
   endtask
   // Register accesses through the host model
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      logic        ack, hit;
      logic [31:0] q;
      pcs_cfg_host_i.access(1'b0, 1'b1, a, be, d, ack, hit, q);
      check_bit("write ack", 1'b1, ack);
   endtask
   task automatic rd(input logic [7:0] a, input logic hitExp, input logic [31:0] e);
      logic        ack, hit;
      logic [31:0] q;
      pcs_cfg_host_i.access(1'b1, 1'b0, a, 4'hF, 32'h0, ack, hit, q);
      check_bit("read ack", 1'b1, ack);
      check_bit("read hit", hitExp, hit);
      check_word("read data", e, q);
   endtask
   // Pulse one event, see its sticky flag, then clear it by writing one
   task automatic flag_case(input pcs_evt_t e, input int pos);
      st = STAT_RESET | (16'h0001 << pos);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= '0;
      rd(CMD_OFS, 1'b1, {st, 16'h0556});
      wr(CMD_OFS, 4'hC, 32'h0000_0000);
      rd(CMD_OFS, 1'b1, {st, 16'h0556});
      wr(CMD_OFS, 4'hC, 32'hFFFF_0000);
      rd(CMD_OFS, 1'b1, {STAT_RESET, 16'h0556});
   endtask
   // Single closing point of the run
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Watchdog, far beyond the roughly 140 cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      stop_test();
   end
   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rd(CMD_OFS, 1'b1, {STAT_RESET, CMD_RESET});
      check_word("ctl", 32'h0, {26'h0, ctl});
      $display("test reset done");
      // Fixed bits ignore writes; other dwords are not ours
      wr(CMD_OFS, 4'hF, 32'hFFFF_FFFF);
      rd(CMD_OFS, 1'b1, {STAT_RESET, 16'h0556});
      wr(8'h08, 4'hF, 32'h0000_0000);
      rd(8'h08, 1'b0, 32'h0);
      rd(CMD_OFS, 1'b1, {STAT_RESET, 16'h0556});
      wr(CMD_OFS, 4'h2, 32'h0000_0000);
      rd(CMD_OFS, 1'b1, {STAT_RESET, 16'h0056});
      $display("test access done");
      // Gating of requests and pins, enables off then on
      for (int i = 0; i < 2; i++) begin
         c = i ? 16'h0556 : 16'h0000;
         wr(CMD_OFS, 4'h3, {16'h0, c});
         ctlExp = '{initiator_en: c[2], mem_space_en: c[1], write_invalidate_en: c[4],
                    parity_report_en: c[6], system_error_drive_en: c[8], int_gate: c[10]};
         check_word("ctl", {26'h0, ctlExp}, {26'h0, ctl});
         @(posedge clk);
         evt <= '{serrReq: 1'b1, perrReq: 1'b1, perrSeen: 1'b1, masterPhase: 1'b1,
                  intPending: 1'b1, memHit: 1'b1, mwiWanted: 1'b1, busWanted: 1'b1,
                  default: 1'b0};
         #1;
         check_bit("busReq", c[2], busReq);
         check_bit("mwiCmd", c[4] & c[2], mwiCmd);
         check_bit("memClaim", c[1], memClaim);
         @(posedge clk);
         #1;
         check_bit("serrOe", c[8], serrOe);
         check_bit("perrOe", c[6], perrOe);
         check_bit("intaOe", ~c[10], intaOe);
         check_bit("pin values", 1'b0, serrO | perrO | intaO);
         @(posedge clk);
         evt <= '{intPending: 1'b1, default: 1'b0};
         st = STAT_RESET | 16'h0008 | {1'b0, c[8], 14'h0} | {7'h0, c[6], 8'h0};
         rd(CMD_OFS, 1'b1, {st, c});
         wr(CMD_OFS, 4'hC, 32'hFFFF_0000);
         @(posedge clk);
         evt <= '0;
      end
      $display("test gating done");
      // Each sticky flag from its own event
      flag_case('{addrParityErr: 1'b1, default: 1'b0}, 15);
      flag_case('{dataParityErr: 1'b1, default: 1'b0}, 15);
      flag_case('{serrReq: 1'b1, default: 1'b0}, 14);
      flag_case('{masterAbort: 1'b1, default: 1'b0}, 13);
      flag_case('{tgtAbortRecv: 1'b1, default: 1'b0}, 12);
      flag_case('{tgtAbortSig: 1'b1, default: 1'b0}, 11);
      flag_case('{perrSeen: 1'b1, masterPhase: 1'b1, default: 1'b0}, 8);
      $display("test flags done");
      // Event and clear in one cycle: the set wins
      fork
         wr(CMD_OFS, 4'hC, 32'hFFFF_0000);
         begin
            @(posedge clk);
            evt <= '{masterAbort: 1'b1, default: 1'b0};
            @(posedge clk);
            evt <= '0;
         end
      join
      rd(CMD_OFS, 1'b1, {STAT_RESET | 16'h2000, 16'h0556});
      // Reset in mid-run drops enables and sticky flags alike
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rd(CMD_OFS, 1'b1, {STAT_RESET, CMD_RESET});
      check_word("ctl", 32'h0, {26'h0, ctl});
      $display("test overlap and reset done");
      stop_test();
   end
endmodule
